// [hdl/cfg_fuse_defines.svh]
`ifndef CFG_FUSE_DEFINES_SVH
`define CFG_FUSE_DEFINES_SVH

// byte addresses in configuration space
`define ADDR_BROWNOUT_POWERUP 22'h30_0002
`define ADDR_WATCHDOG         22'h30_0003
`define ADDR_DEBUG_PROG_STACK 22'h30_0006

// implemented-bit masks (unimplemented bits read zero, ignore writes)
`define MASK_BROWNOUT_POWERUP 8'h0F
`define MASK_WATCHDOG         8'h0F
`define MASK_DEBUG_PROG_STACK 8'h85

// unprogrammed (erased) values
`define RST_BROWNOUT_POWERUP  8'h0F
`define RST_WATCHDOG          8'h0F
`define RST_DEBUG_PROG_STACK  8'h85

// decode registers while reset is held
`define RST_TRIP_LEVEL        2'h3
`define RST_POSTSCALE         8'h01

// field positions
`define POS_POWERUP_DELAY_OFF_N 0
`define POS_BROWNOUT_RESET_ON   1
`define POS_BROWNOUT_THR_LO     2
`define POS_BROWNOUT_THR_HI     3
`define POS_WATCHDOG_FUSE_ON    0
`define POS_WATCHDOG_PS_LO      1
`define POS_WATCHDOG_PS_HI      3
`define POS_STACK_FAULT_RST_ON  0
`define POS_LOW_VOLTAGE_PROG_ON 2
`define POS_DEBUG_OFF_N         7

// power-up delay: time in us, cycles at 40 MHz derived from it
`define POWERUP_DELAY_US     72
`define CORE_CLK_MHZ         40
`define POWERUP_DELAY_CYCLES (`POWERUP_DELAY_US * `CORE_CLK_MHZ)

`endif

// [hdl/cfg_fuse_pkg.sv]
package cfg_fuse_pkg;

  // brown-out trip level, encoded as the fuse field
  typedef enum logic [1:0] {
    TRIP_4V5 = 2'b00,
    TRIP_4V2 = 2'b01,
    TRIP_2V7 = 2'b10,
    TRIP_2V0 = 2'b11
  } trip_level_t;

  typedef enum logic [1:0] {
    PU_IDLE,
    PU_HOLD,
    PU_DONE
  } powerup_state_t;

endpackage : cfg_fuse_pkg

// [hdl/fuse_cell_byte.sv]
`timescale 1ns/1ps
`include "cfg_fuse_defines.svh"

// one configuration byte of non-volatile cells; only implemented bits store
module fuse_cell_byte #(
  parameter logic [7:0] IMPL_MASK = 8'hFF,
  parameter logic [7:0] ERASED    = 8'hFF
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] value
);

  logic [7:0] cell_ff;
  logic [7:0] nxt_cell;

  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_bit
      // unimplemented positions stay zero whatever is written
      always_comb begin
        if (!IMPL_MASK[b]) begin
          nxt_cell[b] = 1'b0;
        end else if (wr_en) begin
          nxt_cell[b] = wr_data[b];
        end else begin
          nxt_cell[b] = cell_ff[b];
        end
      end
    end
  endgenerate

  // reset models an erased array; real cells would hold across reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cell_ff <= ERASED & IMPL_MASK;
    end else begin
      cell_ff <= nxt_cell;
    end
  end

  assign value = cell_ff;

endmodule : fuse_cell_byte

// [hdl/config_fuse_bank.sv]
// Function
// - threshold field 3:2 picks trip: 11=2.0V 10=2.7V 01=4.2V 00=4.5V
// - watchdog postscale field 3:1 divides by two to the code power
// - watchdog fuse one forces watchdog on, else soft enable decides
// - stack fault reset bit one lets stack full or underflow reset
// - bit 2 at 300006h enables low-voltage programming entry
// - bits 7:4 of watchdog and brown-out bytes read zero, ignore writes
// - implemented bits read one erased; programmed zero enables the power-up delay, one applies the other options
// - enabled power-up timer holds reset a fixed delay at power-up only
`timescale 1ns/1ps
`include "cfg_fuse_defines.svh"

module config_fuse_bank #(
  parameter int PU_CYCLES = `POWERUP_DELAY_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  input  wire logic        POWER_ON,
  input  wire logic        TBL_WR,
  input  wire logic [21:0] TBL_ADDR,
  input  wire logic [7:0]  TBL_WDATA,
  output logic      [7:0]  TBL_RDATA,
  input  wire logic        WATCHDOG_SOFT_ON,
  input  wire logic        STACK_FAULT,
  input  wire logic        LV_PROG_REQ,
  output logic      [1:0]  BROWNOUT_TRIP_LEVEL,
  output logic             BROWNOUT_RESET_ARM,
  output logic      [7:0]  WATCHDOG_POSTSCALE,
  output logic             WATCHDOG_RUN,
  output logic             STACK_FAULT_RESET,
  output logic             LV_PROG_ENTRY,
  output logic             POWERUP_HOLD
);

  // stored bytes and their write strobes
  logic [7:0] bp_byte;
  logic [7:0] wd_byte;
  logic [7:0] ds_byte;
  logic       wr_bp;
  logic       wr_wd;
  logic       wr_ds;

  // write decode; each byte written whole by a table write
  // writes to any other address are dropped: the bank has no other cells
  assign wr_bp = TBL_WR && (TBL_ADDR == `ADDR_BROWNOUT_POWERUP);
  assign wr_wd = TBL_WR && (TBL_ADDR == `ADDR_WATCHDOG);
  assign wr_ds = TBL_WR && (TBL_ADDR == `ADDR_DEBUG_PROG_STACK);

  // brown-out / power-up byte, upper nibble unimplemented
  fuse_cell_byte #(
    .IMPL_MASK (`MASK_BROWNOUT_POWERUP),
    .ERASED    (`RST_BROWNOUT_POWERUP)
  ) u_bp (
    .clk     (CORE_CLK),
    .rst_n   (RESETN),
    .wr_en   (wr_bp),
    .wr_data (TBL_WDATA),
    .value   (bp_byte)
  );

  // watchdog byte, upper nibble unimplemented
  fuse_cell_byte #(
    .IMPL_MASK (`MASK_WATCHDOG),
    .ERASED    (`RST_WATCHDOG)
  ) u_wd (
    .clk     (CORE_CLK),
    .rst_n   (RESETN),
    .wr_en   (wr_wd),
    .wr_data (TBL_WDATA),
    .value   (wd_byte)
  );

  // debug / programming / stack byte
  // bit 7 is stored and read back only; nothing here decodes it
  fuse_cell_byte #(
    .IMPL_MASK (`MASK_DEBUG_PROG_STACK),
    .ERASED    (`RST_DEBUG_PROG_STACK)
  ) u_ds (
    .clk     (CORE_CLK),
    .rst_n   (RESETN),
    .wr_en   (wr_ds),
    .wr_data (TBL_WDATA),
    .value   (ds_byte)
  );

  // table read data, registered; unmapped addresses read zero
  // the read lags the address by one edge, like the option decodes
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb begin
    case (TBL_ADDR)
      `ADDR_BROWNOUT_POWERUP: nxt_rdata = bp_byte;
      `ADDR_WATCHDOG:         nxt_rdata = wd_byte;
      `ADDR_DEBUG_PROG_STACK: nxt_rdata = ds_byte;
      default:                nxt_rdata = 8'h00;
    endcase
  end

  // option decode from the stored bytes, registered for clean outputs
  logic [1:0] trip_ff;
  logic       bor_ff;
  logic [7:0] ps_ff;
  logic       wdrun_ff;
  logic       stk_ff;
  logic       lvp_ff;
  logic [1:0] nxt_trip;
  logic       nxt_bor;
  logic [7:0] nxt_ps;
  logic       nxt_wdrun;
  logic       nxt_stk;
  logic       nxt_lvp;
  cfg_fuse_pkg::trip_level_t trip_sel;
  logic [2:0] ps_code;

  always_comb begin
    // the trip code passes through as stored; 11 is the lowest level
    trip_sel = cfg_fuse_pkg::trip_level_t'(
      bp_byte[`POS_BROWNOUT_THR_HI:`POS_BROWNOUT_THR_LO]);
    nxt_trip = trip_sel;
    nxt_bor  = bp_byte[`POS_BROWNOUT_RESET_ON];
    ps_code  = wd_byte[`POS_WATCHDOG_PS_HI:`POS_WATCHDOG_PS_LO];
    nxt_ps   = 8'h01 << ps_code;
    // fuse forces the watchdog on; software only matters when fuse is clear
    nxt_wdrun = wd_byte[`POS_WATCHDOG_FUSE_ON] | WATCHDOG_SOFT_ON;
    // stack fault is a pulse; reset request follows it one cycle later
    nxt_stk  = STACK_FAULT & ds_byte[`POS_STACK_FAULT_RST_ON];
    // entry is refused while the fuse bit is programmed to zero
    nxt_lvp  = LV_PROG_REQ & ds_byte[`POS_LOW_VOLTAGE_PROG_ON];
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      // decodes idle in reset; erased options show one edge after release
      rdata_ff <= 8'h00;
      trip_ff  <= `RST_TRIP_LEVEL;
      bor_ff   <= 1'b0;
      ps_ff    <= `RST_POSTSCALE;
      wdrun_ff <= 1'b0;
      stk_ff   <= 1'b0;
      lvp_ff   <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      trip_ff  <= nxt_trip;
      bor_ff   <= nxt_bor;
      ps_ff    <= nxt_ps;
      wdrun_ff <= nxt_wdrun;
      stk_ff   <= nxt_stk;
      lvp_ff   <= nxt_lvp;
    end
  end

  // power-up timer: counts on the first power-on after reset; later power-ons are ignored
  cfg_fuse_pkg::powerup_state_t pu_state_ff;
  cfg_fuse_pkg::powerup_state_t nxt_pu_state;
  logic [31:0] pu_cnt_ff;
  logic [31:0] nxt_pu_cnt;
  logic        hold_ff;
  logic        nxt_hold;

  // last count of the hold; PU_CYCLES must be at least one, since zero
  // would wrap to the top count and hold for a very long time
  localparam logic [31:0] PU_LAST = 32'(PU_CYCLES - 1);

  always_comb begin
    nxt_pu_state = pu_state_ff;
    nxt_pu_cnt   = pu_cnt_ff;
    nxt_hold     = 1'b0;
    case (pu_state_ff)
      cfg_fuse_pkg::PU_IDLE: begin
        // active-low fuse: zero enables the delay
        if (POWER_ON && !bp_byte[`POS_POWERUP_DELAY_OFF_N]) begin
          nxt_pu_state = cfg_fuse_pkg::PU_HOLD;
          nxt_pu_cnt   = 32'h0000_0000;
          nxt_hold     = 1'b1;
        end else if (POWER_ON) begin
          // delay fuse left erased: no hold at all
          nxt_pu_state = cfg_fuse_pkg::PU_DONE;
        end
      end
      cfg_fuse_pkg::PU_HOLD: begin
        // count runs 0 .. PU_LAST, so the hold stands PU_CYCLES cycles
        if (pu_cnt_ff >= PU_LAST) begin
          nxt_pu_state = cfg_fuse_pkg::PU_DONE;
        end else begin
          nxt_pu_cnt = pu_cnt_ff + 32'h0000_0001;
          nxt_hold   = 1'b1;
        end
      end
      cfg_fuse_pkg::PU_DONE: begin
        // later power-on pulses are ignored until the next reset
        nxt_pu_state = cfg_fuse_pkg::PU_DONE; // only at power-up
      end
      default: nxt_pu_state = cfg_fuse_pkg::PU_IDLE;
    endcase
  end

  // timer state, count and hold register together; a reset rearms it
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      pu_state_ff <= cfg_fuse_pkg::PU_IDLE;
      pu_cnt_ff   <= 32'h0000_0000;
      hold_ff     <= 1'b0;
    end else begin
      pu_state_ff <= nxt_pu_state;
      pu_cnt_ff   <= nxt_pu_cnt;
      hold_ff     <= nxt_hold;
    end
  end

  // every output comes straight from a flip-flop, so no decode glitch
  // reaches the reset, watchdog or programming logic that samples it
  assign TBL_RDATA           = rdata_ff;
  assign BROWNOUT_TRIP_LEVEL = trip_ff;
  assign BROWNOUT_RESET_ARM  = bor_ff;
  assign WATCHDOG_POSTSCALE  = ps_ff;
  assign WATCHDOG_RUN        = wdrun_ff;
  assign STACK_FAULT_RESET   = stk_ff;
  assign LV_PROG_ENTRY       = lvp_ff;
  assign POWERUP_HOLD        = hold_ff;

endmodule : config_fuse_bank

// [tb/config_fuse_bank_sva.sv]
`timescale 1ns/1ps
`include "cfg_fuse_defines.svh"

module config_fuse_bank_sva #(
  parameter int PU_CYCLES = 8
) (
  input wire logic        CORE_CLK,
  input wire logic        RESETN,
  input wire logic        POWER_ON,
  input wire logic [21:0] TBL_ADDR,
  input wire logic [7:0]  TBL_RDATA,
  input wire logic        WATCHDOG_SOFT_ON,
  input wire logic        STACK_FAULT,
  input wire logic        LV_PROG_REQ,
  input wire logic [1:0]  BROWNOUT_TRIP_LEVEL,
  input wire logic        BROWNOUT_RESET_ARM,
  input wire logic [7:0]  WATCHDOG_POSTSCALE,
  input wire logic        WATCHDOG_RUN,
  input wire logic        STACK_FAULT_RESET,
  input wire logic        LV_PROG_ENTRY,
  input wire logic        POWERUP_HOLD
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  // cycles the hold has been seen high, so its length can be judged
  always_comb nxt_cnt = POWERUP_HOLD ? cnt_ff + 16'h0001 : 16'h0000;
  always_ff @(posedge CORE_CLK) cnt_ff <= RESETN ? nxt_cnt : 16'h0000;

  // decodes are compared with the read-back byte of the same cycle
  a_trip_decode: assert property ($past(RESETN) &&
    $past(TBL_ADDR) == `ADDR_BROWNOUT_POWERUP |->
    BROWNOUT_TRIP_LEVEL == TBL_RDATA[3:2] &&
    BROWNOUT_RESET_ARM == TBL_RDATA[1]) else $error("trip decode wrong");
  a_post_decode: assert property ($past(RESETN) &&
    $past(TBL_ADDR) == `ADDR_WATCHDOG |->
    WATCHDOG_POSTSCALE == 8'h01 << TBL_RDATA[3:1])
    else $error("postscale decode wrong");
  a_run_select: assert property ($past(RESETN) &&
    $past(TBL_ADDR) == `ADDR_WATCHDOG |-> WATCHDOG_RUN ==
    (TBL_RDATA[0] | $past(WATCHDOG_SOFT_ON))) else $error("run wrong");
  a_stack_gate: assert property ($past(RESETN) &&
    $past(TBL_ADDR) == `ADDR_DEBUG_PROG_STACK |-> STACK_FAULT_RESET ==
    (TBL_RDATA[0] & $past(STACK_FAULT))) else $error("stack reset wrong");
  a_lvprog_gate: assert property ($past(RESETN) &&
    $past(TBL_ADDR) == `ADDR_DEBUG_PROG_STACK |-> LV_PROG_ENTRY ==
    (TBL_RDATA[2] & $past(LV_PROG_REQ))) else $error("lv entry wrong");
  a_upper_zero: assert property ($past(RESETN) &&
    ($past(TBL_ADDR) == `ADDR_WATCHDOG ||
    $past(TBL_ADDR) == `ADDR_BROWNOUT_POWERUP) |-> TBL_RDATA[7:4] == 4'h0)
    else $error("unused bits not zero");
  a_erased_out: assert property ($past(RESETN) &&
    !$past(RESETN, 2) |->
    WATCHDOG_POSTSCALE == 8'h80 && WATCHDOG_RUN && BROWNOUT_RESET_ARM &&
    BROWNOUT_TRIP_LEVEL == 2'b11) else $error("erased decode wrong");
  a_hold_cause: assert property ($rose(POWERUP_HOLD) |->
    $past(POWER_ON)) else $error("hold without power-up");
  a_hold_length: assert property ($past(RESETN) &&
    $fell(POWERUP_HOLD) |-> cnt_ff == 16'(PU_CYCLES))
    else $error("hold length wrong");
endmodule : config_fuse_bank_sva

bind config_fuse_bank config_fuse_bank_sva #(
  .PU_CYCLES (PU_CYCLES)
) sva_i (
  .CORE_CLK            (CORE_CLK),
  .RESETN              (RESETN),
  .POWER_ON            (POWER_ON),
  .TBL_ADDR            (TBL_ADDR),
  .TBL_RDATA           (TBL_RDATA),
  .WATCHDOG_SOFT_ON    (WATCHDOG_SOFT_ON),
  .STACK_FAULT         (STACK_FAULT),
  .LV_PROG_REQ         (LV_PROG_REQ),
  .BROWNOUT_TRIP_LEVEL (BROWNOUT_TRIP_LEVEL),
  .BROWNOUT_RESET_ARM  (BROWNOUT_RESET_ARM),
  .WATCHDOG_POSTSCALE  (WATCHDOG_POSTSCALE),
  .WATCHDOG_RUN        (WATCHDOG_RUN),
  .STACK_FAULT_RESET   (STACK_FAULT_RESET),
  .LV_PROG_ENTRY       (LV_PROG_ENTRY),
  .POWERUP_HOLD        (POWERUP_HOLD)
);

// [tb/config_fuse_bank_test.sv]
`timescale 1ns/1ps
`include "cfg_fuse_defines.svh"

module config_fuse_bank_test;
  logic        CORE_CLK, RESETN, POWER_ON, TBL_WR, WATCHDOG_SOFT_ON;
  logic        STACK_FAULT, LV_PROG_REQ, BROWNOUT_RESET_ARM, WATCHDOG_RUN;
  logic        STACK_FAULT_RESET, LV_PROG_ENTRY, POWERUP_HOLD;
  logic [21:0] TBL_ADDR;
  logic [7:0]  TBL_WDATA, TBL_RDATA, WATCHDOG_POSTSCALE;
  logic [1:0]  BROWNOUT_TRIP_LEVEL;
  int          bad_count, compares, n;

  // short hold count keeps the run brief
  config_fuse_bank #(
    .PU_CYCLES (8)
  ) dut (
    .CORE_CLK            (CORE_CLK),
    .RESETN              (RESETN),
    .POWER_ON            (POWER_ON),
    .TBL_WR              (TBL_WR),
    .TBL_ADDR            (TBL_ADDR),
    .TBL_WDATA           (TBL_WDATA),
    .TBL_RDATA           (TBL_RDATA),
    .WATCHDOG_SOFT_ON    (WATCHDOG_SOFT_ON),
    .STACK_FAULT         (STACK_FAULT),
    .LV_PROG_REQ         (LV_PROG_REQ),
    .BROWNOUT_TRIP_LEVEL (BROWNOUT_TRIP_LEVEL),
    .BROWNOUT_RESET_ARM  (BROWNOUT_RESET_ARM),
    .WATCHDOG_POSTSCALE  (WATCHDOG_POSTSCALE),
    .WATCHDOG_RUN        (WATCHDOG_RUN),
    .STACK_FAULT_RESET   (STACK_FAULT_RESET),
    .LV_PROG_ENTRY       (LV_PROG_ENTRY),
    .POWERUP_HOLD        (POWERUP_HOLD)
  );

  initial begin
    CORE_CLK = 1'b0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // every driver change lands 1 ns after a rising edge
  task automatic step();
    @(posedge CORE_CLK);
    #1;
  endtask : step

  task automatic wr(input logic [21:0] a, input logic [7:0] d);
    TBL_WR = 1'b1;
    TBL_ADDR = a;
    TBL_WDATA = d;
    step();
    TBL_WR = 1'b0;
  endtask : wr

  // two edges: read data and decodes have both settled afterwards
  task automatic rd(input logic [21:0] a, input logic [7:0] e);
    TBL_ADDR = a;
    step();
    step();
    chk(TBL_RDATA, e);
  endtask : rd

  task automatic finish_test();
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    {RESETN, POWER_ON, TBL_WR, WATCHDOG_SOFT_ON} = 4'h0;
    {STACK_FAULT, LV_PROG_REQ, TBL_ADDR, TBL_WDATA} = 32'h0000_0000;
    bad_count = 0;
    compares = 0;
    repeat (6) @(posedge CORE_CLK);
    #1 RESETN = 1'b1;
    // erased bytes read all implemented ones
    rd(`ADDR_BROWNOUT_POWERUP, 8'h0F);
    chk(WATCHDOG_POSTSCALE, 8'h80);
    rd(`ADDR_WATCHDOG, 8'h0F);
    rd(`ADDR_DEBUG_PROG_STACK, 8'h85);
    // the timer takes one start only, so the enabled case goes first
    wr(`ADDR_BROWNOUT_POWERUP, 8'hFE);
    rd(`ADDR_BROWNOUT_POWERUP, 8'h0E);
    // third pass: a reset erases the cells, so the delay fuse is off
    for (int k = 0; k < 3; k++) begin
      if (k == 2) begin
        RESETN = 1'b0;
        repeat (2) step();
        RESETN = 1'b1;
      end
      POWER_ON = 1'b1;
      step();
      POWER_ON = 1'b0;
      n = 0;
      repeat (12) begin
        if (POWERUP_HOLD === 1'b1) n++;
        step();
      end
      chk(8'(n), k == 0 ? 8'h08 : 8'h00);
    end
    // every postscale code; enable fuse and soft enable both varied
    for (int c = 0; c < 8; c++) begin
      WATCHDOG_SOFT_ON = c[0];
      wr(`ADDR_WATCHDOG, {4'hF, c[2:0], c[1]});
      rd(`ADDR_WATCHDOG, {4'h0, c[2:0], c[1]});
      chk(WATCHDOG_POSTSCALE, 8'h01 << c);
      chk(8'(WATCHDOG_RUN), 8'(c[0] | c[1]));
    end
    // every trip code, brown-out arm following bit 1
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_BROWNOUT_POWERUP, {4'hF, c[1:0], c[0], 1'b1});
      rd(`ADDR_BROWNOUT_POWERUP, {4'h0, c[1:0], c[0], 1'b1});
      chk(8'(BROWNOUT_TRIP_LEVEL), 8'(c));
      chk(8'(BROWNOUT_RESET_ARM), 8'(c[0]));
    end
    // stack reset and low-voltage entry gated by their fuses
    STACK_FAULT = 1'b1;
    LV_PROG_REQ = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_DEBUG_PROG_STACK, {5'h1F, c[1], 1'b1, c[0]});
      rd(`ADDR_DEBUG_PROG_STACK, {5'h10, c[1], 1'b0, c[0]});
      chk(8'(STACK_FAULT_RESET), 8'(c[0]));
      chk(8'(LV_PROG_ENTRY), 8'(c[1]));
    end
    STACK_FAULT = 1'b0;
    LV_PROG_REQ = 1'b0;
    step();
    step();
    chk(8'({STACK_FAULT_RESET, LV_PROG_ENTRY}), 8'h00);
    // unmapped place is ignored and reads zero
    wr(22'h30_0004, 8'h00);
    rd(22'h30_0004, 8'h00);
    rd(`ADDR_BROWNOUT_POWERUP, 8'h0F);
    finish_test();
  end
endmodule : config_fuse_bank_test
